// [bench/chan_datapath_sva.sv]
// Port checker for the channel datapath.
// Assumes binding onto every chan_datapath instance.
`timescale 1ns/100ps
module chan_datapath_chk (
   input wire logic hclk, // Clock
   input wire logic hresetn, // Reset, active low
   input wire logic [31:0] hrdata, // Read data
   input wire logic hreadyout, // Slave ready
   input wire logic hresp, // Response
   input wire logic fabric_en, // Fabric strobe
   input wire chan_datapath_pkg::rx_word_t rx_out, // Received word
   input wire logic rx_cell_valid, // Cell valid
   input wire logic oof_alarm // Out of frame
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
   a_zero_wait: assert property ($past(hresetn) |-> hreadyout) else $error("wait state");
   a_byte_data: assert property (hrdata[31:8] == 24'h0) else $error("wide read");
   a_fabric_rate: assert property (fabric_en |=> !fabric_en [*3] ##1 fabric_en)
      else $error("fabric strobe spacing");
   a_frame_once: assert property (rx_out.frame |=> !rx_out.frame [*3])
      else $error("frame pulse too long");
   a_frame_word: assert property (rx_out.frame |-> rx_out.valid) else $error("frame alone");
   a_frame_lock: assert property (rx_out.frame |-> !oof_alarm) else $error("frame in oof");
   a_cell_pulse: assert property (rx_cell_valid |=> !rx_cell_valid)
      else $error("cell valid too long");
   c_frame: cover property (rx_out.frame);
   c_oof: cover property ($rose(oof_alarm));
   c_word: cover property (rx_out.valid ##4 rx_out.valid);
endmodule
bind chan_datapath chan_datapath_chk u_chan_datapath_chk (.hclk(hclk), .hresetn(hresetn),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fabric_en(fabric_en),
   .rx_out(rx_out), .rx_cell_valid(rx_cell_valid), .oof_alarm(oof_alarm));

// [bench/remote_echo.sv]
// Remote transceiver model: sends back every byte it receives.
// Assumes the byte link runs on the local clock.
`timescale 1ns/100ps
module remote_echo (
   input wire logic clk, // Byte clock
   input wire logic rst_n, // Reset, active low
   input wire logic [7:0] rx_byte, // From local transmitter
   output logic [7:0] tx_byte // To local receiver
);
   // One byte of line delay, so words rejoin off their own phase
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_byte <= 8'h00;
      end else begin
         tx_byte <= rx_byte;
      end
   end
endmodule

// [bench/test_chan_datapath.sv]
// Bench: registers, pass-through bytes, SONET lock and forced faults.
// Assumes remote_echo closes the serial link.
`timescale 1ns/100ps
`include "chan_datapath_defs.svh"
module test_chan_datapath;
   localparam int FRAME_CYC = 48 * 9 * 4;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] tx_word = 32'hA5C35A3C; // Rich in transitions
   logic [2:0] hsize = 3'h0;
   logic [159:0] tx_cell = {8{20'hB4E1D}};
   logic [159:0] rx_cell;
   logic tx_cell_valid = 1'b0;
   logic [31:0] hrdata, rd;
   logic hreadyout, hresp, fabric_en, rx_cell_valid, oof_alarm;
   logic [7:0] ser_tx_byte, ser_rx_byte;
   chan_datapath_pkg::rx_word_t rx_out;
   int bad_count = 0;
   int tests_run = 0;
   int cyc = 0;
   always #12.5 hclk = ~hclk;
   chan_datapath #(.ROW_WORDS(48), .FRAME_ROWS(9), .CELL_W(160)) u_chan_datapath (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .tx_word(tx_word), .tx_cell(tx_cell),
      .tx_cell_valid(tx_cell_valid), .fabric_en(fabric_en), .ser_tx_byte(ser_tx_byte),
      .ser_rx_byte(ser_rx_byte), .rx_out(rx_out), .rx_cell(rx_cell),
      .rx_cell_valid(rx_cell_valid),
      .oof_alarm(oof_alarm));
   remote_echo u_remote_echo (.clk(hclk), .rst_n(hresetn), .rx_byte(ser_tx_byte),
      .tx_byte(ser_rx_byte));
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      hsize <= 3'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         bad_count++;
         close_out();
      end
   end
   initial begin
      int i;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      bus(1'b0, `REG_CTRL, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, `REG_CTRL, 32'hFFFFFF5A);
      bus(1'b0, `REG_CTRL, 32'h0);
      chk(rd, 32'h5A);
      bus(1'b1, `REG_GROUP, 32'hE3);
      bus(1'b0, `REG_GROUP, 32'h0);
      chk(rd, 32'hE3);
      bus(1'b1, 8'h14, 32'hFF);
      bus(1'b0, 8'h14, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, `REG_GROUP, 32'h0);
      bus(1'b1, `REG_CTRL, 32'h0);
      repeat (12) @(posedge hclk);
      i = 0;
      do begin
         @(posedge hclk);
         #1;
         i++;
      end while (ser_tx_byte !== 8'hA5 && i < 200);
      // Word leaves top byte first, one byte a cycle
      for (int k = 0; k < 3; k++) begin
         @(posedge hclk);
         #1;
         chk({24'h0, ser_tx_byte}, {24'h0, tx_word[23-8*k -: 8]});
      end
      bus(1'b1, `REG_CTRL, 32'h25);
      i = 0;
      do begin
         @(posedge hclk);
         #1;
         i++;
      end while (rx_out.frame !== 1'b1 && i < 8000);
      chk({31'h0, rx_out.frame}, 32'h1);
      repeat (FRAME_CYC) @(posedge hclk);
      bus(1'b1, `REG_ALARM, 32'h7);
      bus(1'b0, `REG_STATUS, 32'h0);
      chk(rd & 32'h0F, 32'h01);
      // Bypassed payload word must come back descrambled to what was sent
      i = 0;
      do begin
         @(posedge hclk);
         #1;
         i++;
      end while (!(rx_out.valid && rx_out.spe) && i < 400);
      chk({31'h0, rx_out.spe}, 32'h1);
      chk(rx_out.data, tx_word);
      // Forced K2, then B1, then framing loss last, as it needs relock
      for (i = 2; i >= 0; i--) begin
         bus(1'b1, `REG_FAULT, 32'h1 << i);
         repeat (5 * FRAME_CYC) @(posedge hclk);
         bus(1'b0, `REG_ALARM, 32'h0);
         chk(rd & (32'h1 << i), 32'h1 << i);
         chk({31'h0, oof_alarm}, {31'h0, i == 0});
         bus(1'b1, `REG_FAULT, 32'h0);
         repeat (4 * FRAME_CYC) @(posedge hclk);
         bus(1'b1, `REG_ALARM, 32'h7);
      end
      // Cell mode, lane 0: let words still in flight from SONET mode drain first
      tx_cell_valid <= 1'b1;
      bus(1'b1, `REG_CTRL, 32'h06);
      repeat (64) @(posedge hclk);
      i = 0;
      do begin
         @(posedge hclk);
         #1;
         i++;
      end while (rx_cell_valid !== 1'b1 && i < 4000);
      chk({12'h0, rx_cell[19:0]}, {12'h0, tx_cell[19:0]});
      close_out();
   end
endmodule

// [hw/chan_datapath.sv]
// Per-channel backplane datapath: transmit framer, overhead handling and
// scrambler, byte mux, receive framer, descrambler, deskew and cell slice.
// Assumes an AHB-Lite master on hclk and a serializer exchanging one byte
// per hclk; the receive byte arrives from another domain.
`timescale 1ns/100ps
`include "chan_datapath_defs.svh"
module chan_datapath #(
   parameter int ROW_WORDS = 1080,
   parameter int FRAME_ROWS = 9,
   parameter int CELL_W = 160
) (
   input wire logic hclk, // Bus and datapath clock
   input wire logic hresetn, // Asynchronous reset, active low
   input wire logic hsel, // Slave select
   input wire logic [31:0] haddr, // Byte address
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write when high
   input wire logic [2:0] hsize, // Transfer size
   input wire logic [31:0] hwdata, // Write data
   input wire logic hready, // Bus ready
   output logic [31:0] hrdata, // Read data
   output logic hreadyout, // Slave ready
   output logic hresp, // Always OKAY
   input wire logic [31:0] tx_word, // Fabric transmit word
   input wire logic [CELL_W-1:0] tx_cell, // Fabric cell bits
   input wire logic tx_cell_valid, // Cell bits valid
   output logic fabric_en, // Fabric-rate strobe
   output logic [7:0] ser_tx_byte, // To serializer
   input wire logic [7:0] ser_rx_byte, // From deserializer
   output chan_datapath_pkg::rx_word_t rx_out, // Received word to fabric
   output logic [CELL_W-1:0] rx_cell, // Destriped cell bits
   output logic rx_cell_valid, // Cell bits valid
   output logic oof_alarm // Out-of-frame level
);

   localparam int RW = $clog2(ROW_WORDS);
   localparam int FW = $clog2(FRAME_ROWS);

   // ************************************************
   // Scrambler keystream, one word per call
   // ************************************************
   function automatic logic [38:0] scram_step(input logic [6:0] s);
      logic [6:0] st;
      logic [31:0] ks;
      st = s;
      ks = 32'h00000000;
      for (int i = 31; i >= 0; i--) begin
         ks[i] = st[6];
         st = {st[5:0], st[6] ^ st[5]};
      end
      return {ks, st};
   endfunction

   function automatic logic [7:0] bip8(input logic [31:0] w);
      return w[31:24] ^ w[23:16] ^ w[15:8] ^ w[7:0];
   endfunction

   // ************************************************
   // Register bus
   // ************************************************
   chan_datapath_pkg::ctrl_t ctrl_q;
   chan_datapath_pkg::group_cfg_t grp_q;
   logic [2:0] fault_q;
   logic [2:0] alarm_q;
   logic [2:0] alarm_set;
   logic [4:0] status;
   logic wr_pend_q;
   logic [`REG_ADDR_W-1:0] wr_addr_q;
   logic [7:0] rd_val;
   logic ph_valid;

   assign ph_valid = hsel && hready && htrans[1];

   always_comb begin
      rd_val = 8'h00;
      unique case (haddr[`REG_ADDR_W-1:0])
         `REG_CTRL: rd_val = ctrl_q;
         `REG_FAULT: rd_val = {5'h00, fault_q};
         `REG_GROUP: rd_val = grp_q;
         `REG_STATUS: rd_val = {3'h0, status};
         `REG_ALARM: rd_val = {5'h00, alarm_q};
         default: rd_val = 8'h00;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= `REG_RESET;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_q <= ph_valid && hwrite;
         if (ph_valid) begin
            wr_addr_q <= haddr[`REG_ADDR_W-1:0];
         end
         if (ph_valid && !hwrite) begin
            hrdata <= {24'h000000, rd_val};
         end
      end
   end

   // Control registers written in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= `REG_RESET;
         fault_q <= 3'h0;
         grp_q <= `REG_RESET;
      end else if (wr_pend_q) begin
         unique case (wr_addr_q)
            `REG_CTRL: ctrl_q <= hwdata[7:0];
            `REG_FAULT: fault_q <= hwdata[2:0];
            `REG_GROUP: grp_q <= hwdata[7:0];
            default: ;
         endcase
      end
   end

   // Sticky alarms, write one to clear; a new event beats the clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         alarm_q <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (alarm_set[i]) begin
               alarm_q[i] <= 1'b1;
            end else if (wr_pend_q && wr_addr_q == `REG_ALARM && hwdata[i]) begin
               alarm_q[i] <= 1'b0;
            end
         end
      end
   end

   // ************************************************
   // Rate strobe and transmit frame position
   // ************************************************
   logic [1:0] tx_ph_q;
   logic [RW-1:0] tx_col_q;
   logic [FW-1:0] tx_row_q;
   logic tx_last_col;
   logic tx_last_row;

   assign tx_last_col = tx_col_q == RW'(ROW_WORDS - 1);
   assign tx_last_row = tx_row_q == FW'(FRAME_ROWS - 1);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_ph_q <= 2'd0;
         fabric_en <= 1'b0;
      end else begin
         tx_ph_q <= tx_ph_q + 2'd1;
         fabric_en <= tx_ph_q == (`LAST_PHASE - 2'd1);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_col_q <= '0;
         tx_row_q <= '0;
      end else if (fabric_en) begin
         tx_col_q <= tx_last_col ? '0 : tx_col_q + RW'(1);
         if (tx_last_col) begin
            tx_row_q <= tx_last_row ? '0 : tx_row_q + FW'(1);
         end
      end
   end

   // ************************************************
   // Transmit overhead, scrambler and parity
   // ************************************************
   logic [31:0] cell_word;
   logic [31:0] oh_word;
   logic [31:0] clear_word;
   logic [31:0] tx_mux_q;
   logic [31:0] tx_mux_d;
   logic [6:0] tx_scr_q;
   logic [7:0] tx_bip_q;
   logic [7:0] tx_b1_q;
   logic [38:0] tx_ks;
   logic tx_toh;
   logic tx_row0_toh;
   logic [2:0] tx_lane;

   assign tx_toh = tx_col_q < RW'(`TOH_WORDS);
   assign tx_row0_toh = tx_toh && tx_row_q == '0;
   assign tx_lane = ctrl_q.eight_link ? grp_q.lane : {2'b00, grp_q.lane[0]};
   assign tx_ks = scram_step(tx_scr_q);
   // Striping: the lane picks its slice of the group's cell bus, by lane bit 0 only unless eight_link is set
   assign cell_word = {tx_cell_valid, 11'h000,
      tx_cell[tx_lane * `SLICE_W +: `SLICE_W]};

   always_comb begin
      chan_datapath_pkg::oh_mode_t ohm;
      ohm = ctrl_q.oh_mode;
      if (ctrl_q.mode == chan_datapath_pkg::MODE_CELL && ohm == chan_datapath_pkg::OH_TRANSPARENT) begin
         ohm = chan_datapath_pkg::OH_SECTION; // Cell mode has no fabric overhead source
      end
      if (ohm == chan_datapath_pkg::OH_TRANSPARENT) begin
         oh_word = tx_word;
      end else if (ohm == chan_datapath_pkg::OH_FULL) begin
         oh_word = 32'h00000000;
      end else begin
         oh_word = tx_word;
      end
      if (ohm != chan_datapath_pkg::OH_TRANSPARENT && tx_row_q == '0) begin
         if (tx_col_q <= RW'(`A1_LAST_WORD)) begin
            oh_word = `A1_WORD;
         end else if (tx_col_q <= RW'(`A2_LAST_WORD)) begin
            oh_word = `A2_WORD;
         end
      end
      if (ohm != chan_datapath_pkg::OH_TRANSPARENT && tx_row_q == FW'(`B1_ROW) && tx_col_q == '0) begin
         oh_word = {tx_b1_q, oh_word[23:0]};
      end
      if (ohm == chan_datapath_pkg::OH_FULL && tx_row_q == FW'(`K2_ROW) && tx_col_q == RW'(`K2_WORD)) begin
         oh_word = {`K2_IDLE, 24'h000000};
      end
      // Fault injection acts on whatever overhead source is in use
      if (fault_q[0] && tx_row_q == '0 && tx_col_q <= RW'(`A2_LAST_WORD)) begin
         oh_word = ~oh_word;
      end
      if (fault_q[1] && tx_row_q == FW'(`B1_ROW) && tx_col_q == '0) begin
         oh_word = {~oh_word[31:24], oh_word[23:0]};
      end
      if (fault_q[2] && tx_row_q == FW'(`K2_ROW) && tx_col_q == RW'(`K2_WORD)) begin
         oh_word = {`K2_FAULT, oh_word[23:0]};
      end
      if (tx_toh) begin
         clear_word = oh_word;
      end else if (ctrl_q.mode == chan_datapath_pkg::MODE_CELL) begin
         clear_word = cell_word;
      end else begin
         clear_word = tx_word;
      end
   end

   // Parity runs over the word of this very position, as the receiver counts it
   always_comb begin
      if (grp_q.power_down) begin
         tx_mux_d = 32'h00000000;
      end else if (ctrl_q.mode == chan_datapath_pkg::MODE_PASS) begin
         tx_mux_d = tx_word;
      end else if (tx_row0_toh) begin
         tx_mux_d = clear_word; // Overhead words of the framing row stay unscrambled
      end else begin
         tx_mux_d = clear_word ^ tx_ks[38:7];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_mux_q <= 32'h00000000;
         tx_scr_q <= `SCRAM_SEED;
         tx_bip_q <= 8'h00;
         tx_b1_q <= 8'h00;
      end else if (fabric_en) begin
         tx_mux_q <= tx_mux_d;
         tx_scr_q <= tx_row0_toh ? `SCRAM_SEED : tx_ks[6:0];
         if (tx_last_col && tx_last_row) begin
            tx_b1_q <= tx_bip_q ^ bip8(tx_mux_d);
            tx_bip_q <= 8'h00;
         end else begin
            tx_bip_q <= tx_bip_q ^ bip8(tx_mux_d);
         end
      end
   end

   // ************************************************
   // Byte mux and line loopback
   // ************************************************
   logic [7:0] rx_s1_q;
   logic [7:0] rx_s2_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_s1_q <= 8'h00;
         rx_s2_q <= 8'h00;
         ser_tx_byte <= 8'h00;
      end else begin
         rx_s1_q <= ser_rx_byte;
         rx_s2_q <= rx_s1_q;
         if (ctrl_q.loop_far) begin
            ser_tx_byte <= rx_s2_q;
         end else begin
            ser_tx_byte <= tx_mux_q[8 * (3 - tx_ph_q) +: 8];
         end
      end
   end

   // ************************************************
   // Receive demux and framer
   // ************************************************
   typedef enum {HUNT, SYNC} frm_state_t;
   frm_state_t frm_q;
   logic [7:0] rx_in;
   logic [31:0] rx_sh_q;
   logic [31:0] rx_word;
   logic [1:0] rx_ph_q;
   logic [RW-1:0] rx_col_q;
   logic [FW-1:0] rx_row_q;
   logic [2:0] miss_q;
   logic a1_ok_q;
   logic rx_done;
   logic seam_hit;

   assign rx_in = ctrl_q.loop_near ? ser_tx_byte : rx_s2_q;
   assign rx_word = {rx_sh_q[23:0], rx_in};
   assign rx_done = rx_ph_q == `LAST_PHASE;
   assign seam_hit = rx_word == `A1A2_SEAM;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_sh_q <= 32'h00000000;
         rx_ph_q <= 2'd0;
         rx_col_q <= '0;
         rx_row_q <= '0;
      end else begin
         rx_sh_q <= rx_word;
         if (frm_q == HUNT && seam_hit && ctrl_q.mode != chan_datapath_pkg::MODE_PASS) begin
            rx_ph_q <= `SEAM_PHASE + 2'd1; // Seam fixes byte and word position
            rx_col_q <= RW'(`A2_FIRST_WORD);
            rx_row_q <= '0;
         end else begin
            rx_ph_q <= rx_ph_q + 2'd1;
            if (rx_done) begin
               rx_col_q <= rx_col_q == RW'(ROW_WORDS - 1) ? '0 : rx_col_q + RW'(1);
               if (rx_col_q == RW'(ROW_WORDS - 1)) begin
                  rx_row_q <= rx_row_q == FW'(FRAME_ROWS - 1) ? '0 : rx_row_q + FW'(1);
               end
            end
         end
      end
   end

   logic check_a2;
   assign check_a2 = rx_done && rx_row_q == '0 && rx_col_q == RW'(`A2_FIRST_WORD);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         frm_q <= HUNT;
         miss_q <= 3'd0;
         a1_ok_q <= 1'b0;
      end else begin
         if (rx_done && rx_row_q == '0 && rx_col_q == RW'(`A1_LAST_WORD)) begin
            a1_ok_q <= rx_word == `A1_WORD;
         end
         unique case (frm_q)
            HUNT: begin
               miss_q <= 3'd0;
               if (seam_hit && ctrl_q.mode != chan_datapath_pkg::MODE_PASS) begin
                  frm_q <= SYNC;
               end
            end
            SYNC: begin
               if (ctrl_q.mode == chan_datapath_pkg::MODE_PASS) begin
                  frm_q <= HUNT;
               end else if (check_a2 && !(a1_ok_q && rx_word == `A2_WORD)) begin
                  miss_q <= miss_q + 3'd1;
                  if (miss_q == `OOF_MISSES - 3'd1) begin
                     frm_q <= HUNT;
                  end
               end else if (check_a2) begin
                  miss_q <= 3'd0;
               end
            end
         endcase
      end
   end

   // ************************************************
   // Descrambler, parity and protection-byte checks
   // ************************************************
   logic [6:0] rx_scr_q;
   logic [7:0] rx_bip_q;
   logic [7:0] rx_b1_q;
   logic [38:0] rx_ks;
   logic [31:0] rx_clear;
   logic rx_toh;
   logic rx_row0_toh;

   assign rx_toh = rx_col_q < RW'(`TOH_WORDS);
   assign rx_row0_toh = rx_toh && rx_row_q == '0;
   assign rx_ks = scram_step(rx_scr_q);
   assign rx_clear = rx_row0_toh ? rx_word : rx_word ^ rx_ks[38:7];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_scr_q <= `SCRAM_SEED;
         rx_bip_q <= 8'h00;
         rx_b1_q <= 8'h00;
      end else if (rx_done) begin
         rx_scr_q <= rx_row0_toh ? `SCRAM_SEED : rx_ks[6:0];
         if (rx_col_q == RW'(ROW_WORDS - 1) && rx_row_q == FW'(FRAME_ROWS - 1)) begin
            rx_b1_q <= rx_bip_q ^ bip8(rx_word);
            rx_bip_q <= 8'h00;
         end else begin
            rx_bip_q <= rx_bip_q ^ bip8(rx_word);
         end
      end
   end

   logic in_sync;
   assign in_sync = frm_q == SYNC;

   always_comb begin
      alarm_set = 3'h0;
      alarm_set[`ALM_OOF] = in_sync && check_a2 && !(a1_ok_q && rx_word == `A2_WORD)
         && miss_q == `OOF_MISSES - 3'd1;
      alarm_set[`ALM_B1] = in_sync && rx_done && rx_row_q == FW'(`B1_ROW) && rx_col_q == '0
         && rx_clear[31:24] != rx_b1_q;
      alarm_set[`ALM_K2] = in_sync && rx_done && rx_row_q == FW'(`K2_ROW)
         && rx_col_q == RW'(`K2_WORD) && rx_clear[31:24] == `K2_FAULT;
   end

   // ************************************************
   // Group alignment, deskew and fabric output
   // ************************************************
   logic was_aligned_q;
   logic pd_q;
   logic realign_ok_q;
   logic [32:0] dly_q [4];
   logic [32:0] aligned;
   logic frm_pulse;

   assign frm_pulse = rx_done && rx_row_q == '0 && rx_col_q == '0;
   assign aligned = dly_q[grp_q.deskew];
   assign status = {realign_ok_q, alarm_q[`ALM_K2], alarm_q[`ALM_B1], oof_alarm, in_sync};

   // A channel that never aligned rejoins its group after power-down only once it is in sync
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         was_aligned_q <= 1'b0;
         pd_q <= 1'b0;
         realign_ok_q <= 1'b0;
      end else begin
         pd_q <= grp_q.power_down;
         if (in_sync && !grp_q.power_down) begin
            was_aligned_q <= 1'b1;
         end
         if (pd_q && !grp_q.power_down) begin
            realign_ok_q <= was_aligned_q;
         end else if (in_sync) begin
            realign_ok_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < 4; i++) begin
            dly_q[i] <= 33'h000000000;
         end
      end else if (rx_done) begin
         dly_q[0] <= {!rx_toh, rx_clear};
         for (int i = 1; i < 4; i++) begin
            dly_q[i] <= dly_q[i - 1];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_out <= '0;
         oof_alarm <= 1'b0;
         rx_cell <= '0;
         rx_cell_valid <= 1'b0;
      end else begin
         oof_alarm <= !in_sync && ctrl_q.mode != chan_datapath_pkg::MODE_PASS;
         rx_out.valid <= rx_done && !grp_q.power_down;
         rx_out.frame <= 1'b0;
         rx_cell_valid <= 1'b0;
         if (rx_done && !grp_q.power_down) begin
            unique case (ctrl_q.mode)
               chan_datapath_pkg::MODE_PASS: begin
                  rx_out.data <= rx_word;
                  rx_out.spe <= 1'b0;
               end
               chan_datapath_pkg::MODE_CELL: begin
                  rx_cell <= '0;
                  rx_cell[tx_lane * `SLICE_W +: `SLICE_W] <= aligned[`SLICE_W-1:0];
                  rx_cell_valid <= in_sync && aligned[32] && aligned[31];
               end
               default: begin
                  if (ctrl_q.align_bypass || !realign_ok_q) begin
                     rx_out.data <= rx_clear;
                     rx_out.spe <= !rx_toh;
                  end else begin
                     rx_out.data <= aligned[31:0];
                     rx_out.spe <= aligned[32];
                  end
                  rx_out.frame <= frm_pulse && in_sync;
               end
            endcase
         end
      end
   end

endmodule

// [hw/chan_datapath_defs.svh]
// Constants for the backplane channel datapath: register map, field
// positions, reset values and frame layout.
// Assumes inclusion by bare name from the package and the top module.
`ifndef CHAN_DATAPATH_DEFS_SVH
`define CHAN_DATAPATH_DEFS_SVH

// ************************************************
// Register map
// ************************************************
`define REG_CTRL 8'h00
`define REG_FAULT 8'h04
`define REG_GROUP 8'h08
`define REG_STATUS 8'h0C
`define REG_ALARM 8'h10
`define REG_ADDR_W 8
`define REG_RESET 8'h00

// ************************************************
// Alarm bit positions
// ************************************************
`define ALM_OOF 0
`define ALM_B1 1
`define ALM_K2 2

// ************************************************
// Frame layout, in 32-bit words
// ************************************************
`define TOH_WORDS 11'd36
`define A1_LAST_WORD 11'd11
`define A2_FIRST_WORD 11'd12
`define A2_LAST_WORD 11'd23
`define K2_ROW 4'd4
`define K2_WORD 11'd24
`define B1_ROW 4'd1
`define A1_WORD 32'hF6F6F6F6
`define A2_WORD 32'h28282828
`define A1A2_SEAM 32'hF6F62828
`define K2_FAULT 8'h06
`define K2_IDLE 8'h00
`define SCRAM_SEED 7'h7F
`define OOF_MISSES 3'd4
`define SEAM_PHASE 2'd1
`define LAST_PHASE 2'd3
`define SLICE_W 20

`endif

// [hw/chan_datapath_pkg.sv]
// Types shared by the channel datapath.
// Assumes chan_datapath_defs.svh on the include path.
`include "chan_datapath_defs.svh"
package chan_datapath_pkg;
   typedef enum logic [1:0] {MODE_PASS, MODE_SONET, MODE_CELL, MODE_RSVD} mode_t;
   typedef enum logic [1:0] {OH_TRANSPARENT, OH_SECTION, OH_FULL, OH_RSVD} oh_mode_t;
   typedef enum logic [1:0] {GRP_SINGLE, GRP_PAIR, GRP_QUAD, GRP_EIGHT} group_t;

   typedef struct packed {
      logic loop_far;
      logic loop_near;
      logic align_bypass;
      logic eight_link;
      oh_mode_t oh_mode;
      mode_t mode;
   } ctrl_t;

   typedef struct packed {
      logic [2:0] lane;
      logic [1:0] deskew;
      logic power_down;
      group_t group;
   } group_cfg_t;

   typedef struct packed {
      logic [31:0] data;
      logic spe;
      logic frame;
      logic valid;
   } rx_word_t;
endpackage
